//--- shared/srw_pkg.sv
// shared constants for the supply reset and watchdog supervisor
package srw_pkg;
    localparam int CLK_HZ = 200000000;
    localparam int SUPPLY_COUNT = 6;
    // times in milliseconds
    localparam int EXTEND_MS = 200;
    localparam int DEBOUNCE_MS = 50;
    localparam int TIMEOUT_SEL_LO_MS = 500;
    localparam int TIMEOUT_SEL_HI_MS = 2000;
    localparam int WDT_SEL2_MS = 10000;
    localparam int WDT_SEL3_MS = 60000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam logic [39:0] EXTEND_CYCLES = 40'(64'(EXTEND_MS) * 64'(CYC_PER_MS));
    localparam logic [39:0] DEBOUNCE_CYCLES = 40'(64'(DEBOUNCE_MS) * 64'(CYC_PER_MS));
    localparam logic [39:0] WDT_CYCLES0 = 40'(64'(TIMEOUT_SEL_LO_MS) * 64'(CYC_PER_MS));
    localparam logic [39:0] WDT_CYCLES1 = 40'(64'(TIMEOUT_SEL_HI_MS) * 64'(CYC_PER_MS));
    localparam logic [39:0] WDT_CYCLES2 = 40'(64'(WDT_SEL2_MS) * 64'(CYC_PER_MS));
    localparam logic [39:0] WDT_CYCLES3 = 40'(64'(WDT_SEL3_MS) * 64'(CYC_PER_MS));
    localparam int CNT_W = 40;
    // register bus map (word addresses are byte offsets / 4)
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h1;
    localparam logic [3:0] REG_STATE = 4'h2;
    localparam logic [3:0] REG_CONTROL = 4'h3;
    localparam logic [2:0] STATUS_RESET_BIT = 3'h0;
    localparam logic [2:0] STATUS_WDT_BIT = 3'h1;
    localparam logic [2:0] STATUS_SUPPLY_BIT = 3'h2;
    localparam logic [2:0] MASK_RESET = 3'h7;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage

//--- rtl/srw_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module srw_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rstValue,
    // level
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= rstValue;
            syncOut <= rstValue;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

//--- rtl/srw_debounce.sv
// level debouncer: output follows input only after it stays stable for a set count
`timescale 1ns/1ps
module srw_debounce (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // synchronised level and filtered result
    input wire logic levelIn,
    input wire logic [srw_pkg::CNT_W-1:0] stableCycles,
    output logic levelOut
);
    logic [srw_pkg::CNT_W-1:0] count;
    wire differs = levelIn != levelOut;
    wire expired = count >= stableCycles - 40'h1;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= '0;
            levelOut <= 1'b1;
        end else if (!differs) begin
            count <= '0;
        end else if (expired) begin
            count <= '0;
            levelOut <= levelIn;
        end else begin
            count <= count + 40'h1;
        end
    end
endmodule

//--- rtl/srw_supervisor.sv
// supply reset generator and watchdog supervisor with an Avalon-MM register slave
`timescale 1ns/1ps
module srw_supervisor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // supply fault pins, high means supply below its fault level
    input wire logic [5:0] supplyFault,
    // manual reset and straps
    input wire logic manualReset_n,
    input wire logic reset_extend_strap,
    input wire logic timeout_sel_hi,
    input wire logic timeout_sel_lo,
    // host processor side
    input wire logic watchdog_kick,
    output logic cpuReset_n,
    output logic watchdogIrq,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [5:0] faultSync;
    logic manualSync;
    logic extendSync;
    logic selHiSync;
    logic selLoSync;
    logic kickSync;

    // a fault pin reads as fault during reset, so the cpu reset stays low until supplies prove good
    genvar gi;
    generate
        for (gi = 0; gi < srw_pkg::SUPPLY_COUNT; gi = gi + 1) begin : g_fault
            srw_sync uFault (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .rstValue(1'b1),
                .asyncIn(supplyFault[gi]),
                .syncOut(faultSync[gi])
            );
        end
    endgenerate

    srw_sync uMan (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstValue(1'b1),
        .asyncIn(manualReset_n),
        .syncOut(manualSync)
    );
    // straps are synchronised as well, since a board may rewire them while running
    srw_sync uExt (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstValue(1'b0),
        .asyncIn(reset_extend_strap),
        .syncOut(extendSync)
    );
    srw_sync uSelHi (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstValue(1'b0),
        .asyncIn(timeout_sel_hi),
        .syncOut(selHiSync)
    );
    srw_sync uSelLo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstValue(1'b0),
        .asyncIn(timeout_sel_lo),
        .syncOut(selLoSync)
    );
    srw_sync uKick (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rstValue(1'b0),
        .asyncIn(watchdog_kick),
        .syncOut(kickSync)
    );

    // ----------------------------------------
    // manual reset debounce
    // ----------------------------------------
    // a bouncing switch would otherwise pulse the cpu reset many times
    logic manualClean;
    srw_debounce uDeb (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .levelIn(manualSync),
        .stableCycles(srw_pkg::DEBOUNCE_CYCLES),
        .levelOut(manualClean)
    );

    // ----------------------------------------
    // reset generator
    // ----------------------------------------
    // supply faults restart the stretch; the manual reset never waits for it
    logic [srw_pkg::CNT_W-1:0] stretchCount;
    logic stretching;
    logic softHold;
    wire anyFault = |faultSync;
    wire stretchDone = stretchCount >= srw_pkg::EXTEND_CYCLES - 40'h1;
    wire supplyHold = anyFault | (stretching & extendSync);
    wire next_cpuReset_n = ~supplyHold & manualClean & ~softHold;

    // limitation: a strap change mid-stretch acts at once; the count does not restart for it
    always_ff @(posedge sys_clk) begin
        if (sys_rst || anyFault) begin
            stretchCount <= '0;
        end else if (stretching && !stretchDone) begin
            stretchCount <= stretchCount + 40'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || anyFault) begin
            stretching <= 1'b1;
        end else if (stretchDone) begin
            stretching <= 1'b0;
        end
    end

    // ----------------------------------------
    // cpu reset output
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpuReset_n <= 1'b0;
        end else begin
            cpuReset_n <= next_cpuReset_n;
        end
    end

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // the count stops while the interrupt is up, so the next kick always starts from zero
    logic kickPrev;
    logic [srw_pkg::CNT_W-1:0] wdtCount;
    wire kickPulse = kickSync & ~kickPrev;
    wire [1:0] selCode = {selHiSync, selLoSync};
    wire [srw_pkg::CNT_W-1:0] wdtLimit =
        (selCode == 2'h0) ? srw_pkg::WDT_CYCLES0 :
        (selCode == 2'h1) ? srw_pkg::WDT_CYCLES1 :
        (selCode == 2'h2) ? srw_pkg::WDT_CYCLES2 : srw_pkg::WDT_CYCLES3;
    wire wdtExpire = ~watchdogIrq & (wdtCount >= wdtLimit - 40'h1);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            kickPrev <= 1'b0;
        end else begin
            kickPrev <= kickSync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || kickPulse) begin
            wdtCount <= '0;
        end else if (!watchdogIrq && !wdtExpire) begin
            wdtCount <= wdtCount + 40'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || kickPulse) begin
            watchdogIrq <= 1'b0;
        end else if (wdtExpire) begin
            watchdogIrq <= 1'b1;
        end
    end

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    // previous values reset to the levels held in reset, so leaving reset makes no false event
    logic cpuResetPrev;
    logic faultPrev;
    wire resetEvent = cpuResetPrev & ~cpuReset_n;
    wire faultEvent = anyFault & ~faultPrev;
    wire [2:0] eventVec = {faultEvent, wdtExpire, resetEvent};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpuResetPrev <= 1'b0;
            faultPrev <= 1'b1;
        end else begin
            cpuResetPrev <= cpuReset_n;
            faultPrev <= anyFault;
        end
    end

    // ----------------------------------------
    // avalon-mm slave: one wait cycle, answer on the second edge
    // ----------------------------------------
    // a write lands at the edge where the master sees waitrequest low, never earlier
    logic accessDone;
    logic [2:0] status;
    logic [2:0] mask;
    wire access = (avs_read | avs_write) & ~accessDone;
    wire writeHit = avs_write & ~avs_waitrequest;
    wire clearStatus = writeHit & (avs_address == srw_pkg::REG_STATUS);
    wire writeMask = writeHit & (avs_address == srw_pkg::REG_MASK);
    wire writeCtl = writeHit & (avs_address == srw_pkg::REG_CONTROL);
    wire [2:0] clearBits = clearStatus ? avs_writedata[2:0] : 3'h0;
    // set wins over clear so no event slips past a write-one-to-clear
    wire [2:0] next_status = (status & ~clearBits) | eventVec;
    wire [2:0] next_mask = writeMask ? avs_writedata[2:0] : mask;
    wire next_softHold = writeCtl ? avs_writedata[0] : softHold;
    // the interrupt follows a new mask at the same edge, so no stale cycle after a mask write
    wire next_irq = |(next_status & next_mask);
    wire [31:0] stateWord = {20'h0, selHiSync, selLoSync, extendSync, manualClean,
        watchdogIrq, cpuReset_n, faultSync};
    // unmapped words read as zero and ignore writes; no error is signalled
    wire [31:0] readMux =
        (avs_address == srw_pkg::REG_STATUS) ? {29'h0, status} :
        (avs_address == srw_pkg::REG_MASK) ? {29'h0, mask} :
        (avs_address == srw_pkg::REG_STATE) ? stateWord :
        (avs_address == srw_pkg::REG_CONTROL) ? {31'h0, softHold} : srw_pkg::READ_UNMAPPED;

    // ----------------------------------------
    // status register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status <= 3'h0;
        end else begin
            status <= next_status;
        end
    end

    // ----------------------------------------
    // mask register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask <= srw_pkg::MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            softHold <= 1'b0;
        end else begin
            softHold <= next_softHold;
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accessDone <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            accessDone <= access;
            avs_waitrequest <= ~access;
            avs_readdata <= access ? readMux : 32'h0;
        end
    end

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule

//--- dv/srw_supervisor_chk.sv
// port checks of the supply reset and watchdog supervisor
`timescale 1ns/1ps
module srw_supervisor_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // pins
    input wire logic [5:0] supplyFault,
    input wire logic reset_extend_strap,
    input wire logic timeout_sel_hi,
    input wire logic timeout_sel_lo,
    input wire logic watchdog_kick,
    input wire logic cpuReset_n,
    input wire logic watchdogIrq,
    // bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // cycles since last fault or kick at the pins; margin of 8 covers the synchronisers
    logic [39:0] goodCnt;
    logic [39:0] kickCnt;
    wire logic [39:0] wdtLim = timeout_sel_hi ? (timeout_sel_lo ? srw_pkg::WDT_CYCLES3 : srw_pkg::WDT_CYCLES2)
        : (timeout_sel_lo ? srw_pkg::WDT_CYCLES1 : srw_pkg::WDT_CYCLES0);
    always_ff @(posedge sys_clk) begin
        goodCnt <= (sys_rst || supplyFault != 6'h00) ? 40'h0 : goodCnt + 40'h1;
        kickCnt <= (sys_rst || watchdog_kick) ? 40'h0 : kickCnt + 40'h1;
    end
    property p_fault_low; (supplyFault != 6'h00) [*4] |-> !cpuReset_n; endproperty
    a_fault_low: assert property (p_fault_low) else $error("reset high during fault");
    property p_release; $rose(cpuReset_n) |-> $past(supplyFault, 3) == 6'h00; endproperty
    a_release: assert property (p_release) else $error("reset released with fault");
    property p_stretch; $rose(cpuReset_n) && reset_extend_strap |-> goodCnt + 40'h8 >= srw_pkg::EXTEND_CYCLES; endproperty
    a_stretch: assert property (p_stretch) else $error("stretch cut short");
    property p_wdt_late; $rose(watchdogIrq) |-> kickCnt + 40'h8 >= wdtLim; endproperty
    a_wdt_late: assert property (p_wdt_late) else $error("watchdog fired early");
    property p_wdt_clear; $rose(watchdog_kick) |-> ##[1:6] !watchdogIrq; endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("kick did not clear interrupt");
    property p_answer; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_once; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_once: assert property (p_once) else $error("answer held too long");
    property p_rest; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
    a_rest: assert property (p_rest) else $error("read data not zero at rest");
endmodule
bind srw_supervisor srw_supervisor_chk srw_supervisor_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .supplyFault(supplyFault), .reset_extend_strap(reset_extend_strap), .timeout_sel_hi(timeout_sel_hi),
    .timeout_sel_lo(timeout_sel_lo), .watchdog_kick(watchdog_kick), .cpuReset_n(cpuReset_n),
    .watchdogIrq(watchdogIrq), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata));

//--- dv/srw_host_model.sv
// host processor model that kicks the watchdog
`timescale 1ns/1ps
module srw_host_model #(parameter int KICK_PERIOD = 40) (
    // clock
    input wire logic sys_clk,
    // watchdog trigger
    output logic watchdog_kick
);
    int cnt = 0;
    initial watchdog_kick = 1'b0;
    // pulse of 4 cycles so the two-stage synchroniser cannot miss it
    always @(posedge sys_clk) begin
        cnt <= (cnt == KICK_PERIOD - 1) ? 0 : cnt + 1;
        watchdog_kick <= (cnt < 4);
    end
endmodule

//--- dv/tb_top.sv
// self-checking bench of the supply reset and watchdog supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] supplyFault = 6'h00;
    logic manualReset_n = 1'b1;
    logic strap = 1'b0;
    logic selHi = 1'b0;
    logic selLo = 1'b0;
    logic kick;
    logic cpuReset_n;
    logic watchdogIrq;
    logic irq;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] rd;
    int err_count = 0;
    int tests_run = 0;
    srw_supervisor srw_supervisor_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .supplyFault(supplyFault),
        .manualReset_n(manualReset_n), .reset_extend_strap(strap), .timeout_sel_hi(selHi),
        .timeout_sel_lo(selLo), .watchdog_kick(kick), .cpuReset_n(cpuReset_n), .watchdogIrq(watchdogIrq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
    srw_host_model srw_host_model_i (.sys_clk(sys_clk), .watchdog_kick(kick));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // called just after a rising edge; the request stands until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // one idle edge so the next call never raises a strobe in this time step
        @(posedge sys_clk);
    endtask
    task automatic t_regs();
        bus(1'b0, srw_pkg::REG_MASK, 32'h0);
        `CHK(rd[2:0], srw_pkg::MASK_RESET)
        bus(1'b1, 4'h9, 32'hffffffff);
        bus(1'b0, 4'h9, 32'h0);
        `CHK(rd, srw_pkg::READ_UNMAPPED)
        for (int i = 0; i < 4; i++) begin
            selHi <= i[1];
            selLo <= i[0];
            strap <= i[0];
            repeat (4) @(posedge sys_clk);
            bus(1'b0, srw_pkg::REG_STATE, 32'h0);
            `CHK(rd[11:9], {i[1:0], i[0]})
            `CHK(rd[6], !i[0])
        end
    endtask
    task automatic t_fault();
        strap <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            supplyFault <= 6'h01 << i;
            repeat (5) @(posedge sys_clk);
            `CHK(cpuReset_n, 1'b0)
            bus(1'b0, srw_pkg::REG_STATE, 32'h0);
            `CHK(rd[5:0], 6'h01 << i)
            `CHK(irq, 1'b1)
        end
        supplyFault <= 6'h00;
        repeat (5) @(posedge sys_clk);
        `CHK(cpuReset_n, 1'b1)
        bus(1'b1, srw_pkg::REG_STATUS, 32'h7);
        bus(1'b0, srw_pkg::REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h0)
        `CHK(irq, 1'b0)
        bus(1'b1, srw_pkg::REG_MASK, 32'h0);
        supplyFault <= 6'h21;
        repeat (5) @(posedge sys_clk);
        bus(1'b0, srw_pkg::REG_STATUS, 32'h0);
        `CHK(rd[srw_pkg::STATUS_SUPPLY_BIT], 1'b1)
        `CHK(irq, 1'b0)
        bus(1'b1, srw_pkg::REG_MASK, 32'h4);
        `CHK(irq, 1'b1)
        supplyFault <= 6'h00;
        repeat (5) @(posedge sys_clk);
        `CHK(cpuReset_n, 1'b1)
        bus(1'b1, srw_pkg::REG_CONTROL, 32'h1);
        @(posedge sys_clk);
        `CHK(cpuReset_n, 1'b0)
        bus(1'b1, srw_pkg::REG_CONTROL, 32'h0);
        @(posedge sys_clk);
        `CHK(cpuReset_n, 1'b1)
        bus(1'b1, srw_pkg::REG_STATUS, 32'h7);
        `CHK(irq, 1'b0)
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_regs();
        t_fault();
        `CHK(watchdogIrq, 1'b0)
        test_done();
    end
endmodule
